// >>> shared/loop_pkg.sv
// constants and types for the nested loop counter
package loop_pkg;
   localparam int LEVELS = 2;
   localparam int CNT_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int WORD_W = LEVELS * CNT_W + 2 * LEVELS;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   typedef enum logic [0:0] {ST_IDLE, ST_RUN} loop_state_type;
endpackage

// >>> shared/stream_if.sv
// valid/ready word stream between loop core and its output fifo
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> src/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(parameter int W = 8, parameter int DEPTH = 4)
(
   input wire logic mclk, // clock
   input wire logic reset_n, // synchronous reset, active low
   stream_if.snk wr, // filling side
   output logic out_valid, // head word present
   input wire logic out_ready, // drain side accepts
   output logic [W-1:0] out_data // head word, registered
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] used_ff;
   logic [W-1:0] head_ff;
   logic head_vld_ff;
   wire push = wr.valid && wr.ready;
   wire pop_mem = (used_ff != '0) && (!head_vld_ff || out_ready);
   assign wr.ready = (used_ff != (AW+1)'(DEPTH));
   assign out_valid = head_vld_ff;
   assign out_data = head_ff;
   always_ff @(posedge mclk)
   begin
      if (push)
         mem_ff[wptr_ff] <= wr.data;
   end
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         used_ff <= '0;
         head_vld_ff <= 1'b0;
         head_ff <= '0;
      end
      else
      begin
         if (push)
            wptr_ff <= wptr_ff + 1'b1;
         if (pop_mem)
         begin
            rptr_ff <= rptr_ff + 1'b1;
            head_ff <= mem_ff[rptr_ff];
         end
         used_ff <= used_ff + (AW+1)'(push) - (AW+1)'(pop_mem);
         if (pop_mem)
            head_vld_ff <= 1'b1;
         else if (out_ready)
            head_vld_ff <= 1'b0;
      end
   end
endmodule // word_fifo

// >>> src/nested_loop_counter.sv
// nested loop counter with fifo-buffered result stream
`timescale 1ns/1ps
module nested_loop_counter
   import loop_pkg::*;
(
   input wire logic mclk, // 125 MHz clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic go, // start strobe
   input wire logic [LEVELS*CNT_W-1:0] limits, // limit vector, element 0 at low bits
   input wire logic run_allow, // enable / forward flow control
   output logic result_ok, // count output valid
   output logic [LEVELS*CNT_W-1:0] count, // counter vector
   output logic [LEVELS-1:0] first_mark, // counter at zero
   output logic [LEVELS-1:0] last_mark, // counter at limit minus one
   output logic busy, // sequence in progress
   input wire logic out_ready // downstream takes result
);
   loop_state_type state_ff, nxt_state;
   logic [CNT_W-1:0] lim_ff [LEVELS];
   logic [CNT_W-1:0] cnt_ff [LEVELS];
   logic [CNT_W-1:0] nxt_cnt [LEVELS];
   logic [LEVELS-1:0] at_last;
   logic [LEVELS-1:0] at_first;
   logic [LEVELS*CNT_W-1:0] cnt_vec;
   stream_if #(.W(WORD_W)) st ();
   logic [WORD_W-1:0] out_word;

   function automatic logic [CNT_W-1:0] elem(input logic [LEVELS*CNT_W-1:0] v, input int i);
      elem = v[i*CNT_W +: CNT_W];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // mark decode
   always_comb
   begin
      for (int i = 0; i < LEVELS; i++)
      begin
         at_first[i] = (cnt_ff[i] == CNT_ZERO);
         at_last[i] = (cnt_ff[i] == lim_ff[i] - CNT_ONE);
         cnt_vec[i*CNT_W +: CNT_W] = cnt_ff[i];
      end
   end

   // a step happens only when enabled, running and the fifo has room
   wire step = (state_ff == ST_RUN) && run_allow && st.ready;
   wire final_iter = &at_last;

   always_comb
   begin
      logic carry;
      carry = 1'b1;
      for (int i = LEVELS - 1; i >= 0; i--)
      begin
         nxt_cnt[i] = cnt_ff[i];
         if (carry)
            nxt_cnt[i] = at_last[i] ? CNT_ZERO : cnt_ff[i] + CNT_ONE;
         carry = carry && at_last[i];
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (go) nxt_state = ST_RUN;
         ST_RUN: if (step && final_iter && !go) nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge mclk)
   begin
      for (int i = 0; i < LEVELS; i++)
      begin
         if (!reset_n)
         begin
            lim_ff[i] <= CNT_ZERO;
            cnt_ff[i] <= CNT_ZERO;
         end
         else if (go)
         begin
            lim_ff[i] <= elem(limits, i);
            cnt_ff[i] <= CNT_ZERO;
         end
         else if (step)
            cnt_ff[i] <= nxt_cnt[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // present vector
   assign st.valid = step;
   assign st.data = {at_last, at_first, cnt_vec};

   // fifo decouples the count stream from a downstream that may stall
   word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .wr(st),
      .out_valid(result_ok),
      .out_ready(out_ready),
      .out_data(out_word)
   );

   assign count = out_word[LEVELS*CNT_W-1:0];
   assign first_mark = out_word[LEVELS*CNT_W +: LEVELS];
   assign last_mark = out_word[LEVELS*CNT_W+LEVELS +: LEVELS];
   assign busy = (state_ff == ST_RUN);
endmodule // nested_loop_counter

// >>> tb/loop_sva.sv
// port assertions for the nested loop counter
`timescale 1ns/1ps
module loop_sva
(
   input wire logic mclk, // clock
   input wire logic reset_n, // reset
   input wire logic go, // start
   input wire logic [15:0] limits, // limits
   input wire logic run_allow, // enable
   input wire logic result_ok, // valid
   input wire logic [15:0] count, // counts
   input wire logic [1:0] first_mark, // first
   input wire logic [1:0] last_mark, // last
   input wire logic busy, // running
   input wire logic out_ready // taken
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [15:0] lim_ff;
   wire tk = result_ok && out_ready;
   always_ff @(posedge mclk)
   begin
      if (go)
         lim_ff <= limits;
   end
   AST_RANGE: assert property (result_ok |-> count[7:0] < lim_ff[7:0]
      && count[15:8] < lim_ff[15:8]) else $error("count out of range");
   AST_FIRST: assert property (result_ok |->
      first_mark == {count[15:8] == 8'h00, count[7:0] == 8'h00}) else $error("first mark");
   AST_LAST: assert property (result_ok |-> last_mark ==
      {count[15:8] == lim_ff[15:8] - 8'h01, count[7:0] == lim_ff[7:0] - 8'h01})
      else $error("last mark");
   AST_HOLD: assert property (result_ok && !out_ready |=> result_ok && $stable(count))
      else $error("word dropped");
   AST_STEP: assert property (tk ##1 result_ok && count[15:8] != 8'h00 |->
      count == $past(count) + 16'h0100) else $error("inner step");
   AST_WRAP: assert property (tk && last_mark == 2'b10 ##1 result_ok && count[7:0] != 8'h00
      |-> count == {8'h00, $past(count[7:0]) + 8'h01}) else $error("outer carry");
   AST_DONE: assert property (tk && last_mark == 2'b11 && !busy |=> !result_ok)
      else $error("output after end");
   AST_GO: assert property (go |=> busy)
      else $error("no start");
   cover property (tk && last_mark == 2'b11);
   cover property (result_ok && !out_ready);
   cover property (go ##1 busy && run_allow);
endmodule // loop_sva
bind nested_loop_counter loop_sva u_loop_sva (.mclk, .reset_n, .go, .limits, .run_allow,
   .result_ok, .count, .first_mark, .last_mark, .busy, .out_ready);

// >>> tb/result_sink.sv
// downstream sink, prompt or stalling
`timescale 1ns/1ps
module result_sink
(
   input wire logic mclk, // clock
   input wire logic reset_n, // reset
   input wire logic slow, // stall mode
   output logic out_ready // accepts
);
   logic [1:0] pace_ff;
   always_ff @(posedge mclk)
   begin
      pace_ff <= reset_n ? pace_ff + 2'h1 : 2'h0;
   end
   assign out_ready = !slow || pace_ff == 2'h3;
endmodule // result_sink

// >>> tb/tb.sv
// self-checking bench for the nested loop counter
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0, reset_n = 1'b0, go = 1'b0, run_allow = 1'b0, slow = 1'b0;
   logic [15:0] limits = 16'h0000, count;
   logic result_ok, busy, out_ready;
   logic [1:0] first_mark, last_mark;
   int error_cnt = 0, tests_run = 0;
   nested_loop_counter u_nested_loop_counter (.mclk, .reset_n, .go, .limits, .run_allow,
      .result_ok, .count, .first_mark, .last_mark, .busy, .out_ready);
   result_sink u_result_sink (.mclk, .reset_n, .slow, .out_ready);
   initial
   begin
      forever #4 mclk = ~mclk;
   end
   task chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one loop sequence; the sink's pace and a gappy enable stress flow control
   task seq(input logic [7:0] o, input logic [7:0] i, input logic sl, input logic gap);
      logic [7:0] eo, ei;
      logic [19:0] w;
      int n;
      eo = 8'h00;
      ei = 8'h00;
      n = 0;
      slow <= sl;
      limits <= {i, o};
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (300)
      begin
         @(posedge mclk);
         run_allow <= gap ? ~run_allow : 1'b1;
         if (result_ok === 1'b1 && out_ready === 1'b1)
         begin
            w = {ei, eo, ei == 8'h00, eo == 8'h00, ei == i - 8'h01, eo == o - 8'h01};
            chk("word", {count, first_mark, last_mark}, w);
            n++;
            ei = (ei == i - 8'h01) ? 8'h00 : ei + 8'h01;
            if (ei == 8'h00)
               eo++;
         end
      end
      chk("words", 20'(n), 20'(o * i));
      chk("idle", {19'h0, result_ok | busy}, 20'h0);
   endtask
   task scn_walk;
      seq(8'h02, 8'h03, 1'b0, 1'b0);
   endtask
   task scn_stall;
      seq(8'h01, 8'h08, 1'b1, 1'b0);
   endtask
   task scn_gap;
      seq(8'h03, 8'h01, 1'b0, 1'b1);
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      chk("reset", {19'h0, result_ok | busy}, 20'h0);
      scn_walk;
      scn_stall;
      scn_gap;
      complete_run;
   end
   initial
   begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      complete_run;
   end
endmodule // tb
